// ---- inc/aux_pin_pkg.sv ----
package aux_pin_pkg;
    // clock and timing
    localparam int unsigned CLOCK_HZ = 200_000_000;
    localparam int unsigned HOLD_TIME_S = 5;
    localparam int unsigned PULSE_TIME_MS = 30;
    localparam longint unsigned HOLD_CYCLES = longint'(HOLD_TIME_S) * CLOCK_HZ;
    localparam longint unsigned PULSE_CYCLES = (longint'(PULSE_TIME_MS) * CLOCK_HZ) / 1000;
    localparam int unsigned COUNT_W = 32;

    // profile select codes
    localparam logic [1:0] PROFILE_HALL = 2'h0;
    localparam logic [1:0] PROFILE_TOUCH_HOLD = 2'h1;
    localparam logic [1:0] PROFILE_STRAP = 2'h2;
    localparam logic [1:0] PROFILE_FORCED = 2'h3;

    // otp byte field positions
    localparam int unsigned PROFILE_LSB = 0;
    localparam int unsigned POLARITY_BIT = 0;
    localparam int unsigned ADDR_SEL_BIT = 1;

    // i2c addresses
    localparam logic [6:0] I2C_ADDR_BASE = 7'h44;
    localparam logic [6:0] I2C_ADDR_ALT = 7'h45;
    localparam logic [6:0] I2C_ADDR_STRAP_MASK = 7'h02;

    // hall compensation
    localparam int unsigned HALL_W = 16;
    localparam int unsigned SCALE_SHIFT = 16;

    typedef struct packed {
        logic out;
        logic oe;
        logic in;
    } pin_s;

    typedef struct packed {
        logic [7:0] system_byte;
        logic [7:0] profile_byte;
    } otp_s;
endpackage

// ---- rtl/hall_threshold_scaler.sv ----
`timescale 1ns/1ps
module hall_threshold_scaler (
    input wire logic clock_i, // system clock
    input wire logic rst_i, // async reset, active high
    input wire logic enable_i, // compensation enable
    input wire logic [aux_pin_pkg::HALL_W-1:0] threshold_i, // nominal threshold counts
    input wire logic [aux_pin_pkg::HALL_W-1:0] hall_out_i, // present hall output
    input wire logic [aux_pin_pkg::HALL_W-1:0] hall_ref_i, // hall output at calibration
    output logic [aux_pin_pkg::HALL_W-1:0] threshold_o // effective threshold counts
);
    localparam int unsigned W = aux_pin_pkg::HALL_W;
    logic [2*W-1:0] product;
    logic [W-1:0] scaled;

    always_comb begin
        product = 32'(threshold_i) * 32'(hall_out_i);
        // zero reference would divide by zero: fall back to nominal
        if (hall_ref_i == '0) begin
            scaled = threshold_i;
        end else begin
            scaled = W'(product / 32'(hall_ref_i));
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            threshold_o <= '0;
        end else begin
            threshold_o <= enable_i ? scaled : threshold_i;
        end
    end
endmodule

// ---- rtl/reset_profile_aux_pin_logic.sv ----
`timescale 1ns/1ps
module reset_profile_aux_pin_logic (
    input wire logic clock_i, // 200 MHz clock
    input wire logic rst_i, // async reset, active high
    input wire aux_pin_pkg::otp_s otp_i, // otp system and profile bytes
    input wire logic self_cap_touch_i, // self-cap channel touch state
    input wire logic host_release_i, // host reconfigures pin, ends forced mode
    input wire logic second_aux_pin_i, // pad level read back
    output logic second_aux_pin_o, // pad output level
    output logic second_aux_pin_oe_o, // pad output enable, high drives
    output logic [6:0] i2c_address_o, // latched i2c target address
    output logic [1:0] profile_o, // active profile
    input wire logic hall_comp_en_i, // hall compensation enable
    input wire logic [15:0] hall_threshold_counts_i, // nominal hall threshold
    input wire logic [15:0] hall_out_i, // hall output
    input wire logic [15:0] hall_ref_i, // hall output at calibration
    output logic [15:0] hall_threshold_counts_o // effective hall threshold
);
    localparam logic [aux_pin_pkg::COUNT_W-1:0] HOLD_CNT =
        aux_pin_pkg::COUNT_W'(aux_pin_pkg::HOLD_CYCLES);
    localparam logic [aux_pin_pkg::COUNT_W-1:0] PULSE_CNT =
        aux_pin_pkg::COUNT_W'(aux_pin_pkg::PULSE_CYCLES);

    typedef enum logic [3:0] {
        IDLE = 4'h1,
        HOLDING = 4'h2,
        PULSING = 4'h4,
        WAIT_RELEASE = 4'h8
    } hold_state_e;

    hold_state_e state;
    logic [aux_pin_pkg::COUNT_W-1:0] count;
    logic [1:0] profile;
    logic polarity_od;
    logic addr_sel;
    logic [1:0] init_steps;
    logic strap_done;
    logic forced_active;
    logic pulse_active;
    logic assert_active;

    assign profile = otp_i.profile_byte[aux_pin_pkg::PROFILE_LSB +: 2];
    assign polarity_od = otp_i.system_byte[aux_pin_pkg::POLARITY_BIT];
    assign addr_sel = otp_i.system_byte[aux_pin_pkg::ADDR_SEL_BIT];
    assign profile_o = profile;

    // touch-hold timing only in its profile
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= IDLE;
            count <= '0;
        end else if (profile != aux_pin_pkg::PROFILE_TOUCH_HOLD) begin
            state <= IDLE;
            count <= '0;
        end else begin
            unique case (state)
                IDLE: begin
                    count <= '0;
                    if (self_cap_touch_i) begin
                        state <= HOLDING;
                        count <= 32'h00000001;
                    end
                end
                HOLDING: begin
                    if (!self_cap_touch_i) begin
                        state <= IDLE;
                        count <= '0;
                    end else if (count >= HOLD_CNT) begin
                        state <= PULSING;
                        count <= '0;
                    end else begin
                        count <= count + 32'h00000001;
                    end
                end
                PULSING: begin
                    if (count >= PULSE_CNT - 32'h00000001) begin
                        state <= WAIT_RELEASE;
                        count <= '0;
                    end else begin
                        count <= count + 32'h00000001;
                    end
                end
                WAIT_RELEASE: begin
                    count <= '0;
                    if (!self_cap_touch_i) begin
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    assign pulse_active = (state == PULSING);

    // strap is caught one clock after reset release, never under reset itself
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            init_steps <= 2'h0;
        end else if (init_steps != 2'h3) begin
            init_steps <= init_steps + 2'h1;
        end
    end

    assign strap_done = (init_steps != 2'h0);

    // sample once after release, then hold
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            i2c_address_o <= aux_pin_pkg::I2C_ADDR_BASE;
        end else if (!strap_done) begin
            i2c_address_o <= addr_sel ? aux_pin_pkg::I2C_ADDR_ALT
                                      : aux_pin_pkg::I2C_ADDR_BASE;
            if (profile == aux_pin_pkg::PROFILE_STRAP && !second_aux_pin_i) begin
                i2c_address_o <= (addr_sel ? aux_pin_pkg::I2C_ADDR_ALT
                                           : aux_pin_pkg::I2C_ADDR_BASE)
                                 | aux_pin_pkg::I2C_ADDR_STRAP_MASK;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            forced_active <= 1'b1;
        end else if (host_release_i) begin
            forced_active <= 1'b0;
        end
    end

    always_comb begin
        assert_active = 1'b0;
        unique case (profile)
            aux_pin_pkg::PROFILE_TOUCH_HOLD: assert_active = pulse_active;
            aux_pin_pkg::PROFILE_FORCED: assert_active = forced_active;
            aux_pin_pkg::PROFILE_HALL: assert_active = 1'b0;
            aux_pin_pkg::PROFILE_STRAP: assert_active = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            second_aux_pin_o <= 1'b0;
            second_aux_pin_oe_o <= 1'b0;
        end else if (profile == aux_pin_pkg::PROFILE_STRAP) begin
            // strap profile keeps the pin an input
            second_aux_pin_o <= 1'b0;
            second_aux_pin_oe_o <= 1'b0;
        end else if (polarity_od) begin
            second_aux_pin_o <= 1'b0;
            second_aux_pin_oe_o <= assert_active;
        end else begin
            second_aux_pin_o <= assert_active;
            second_aux_pin_oe_o <= 1'b1;
        end
    end

    hall_threshold_scaler scaler (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(hall_comp_en_i),
        .threshold_i(hall_threshold_counts_i),
        .hall_out_i(hall_out_i),
        .hall_ref_i(hall_ref_i),
        .threshold_o(hall_threshold_counts_o)
    );
endmodule

// ---- verification/aux_pad_model.sv ----
`timescale 1ns/1ps
module aux_pad_model (
    input wire logic out_i, // pad data
    input wire logic oe_i, // pad enable
    input wire logic strap_low_i, // board ties pin to ground
    output logic level_o // wire level
);
    assign level_o = oe_i ? out_i : !strap_low_i;
endmodule

// ---- verification/aux_pin_props.sv ----
`timescale 1ns/1ps
module aux_pin_props (
    input wire logic clock_i, // clock
    input wire logic rst_i, // reset
    input wire aux_pin_pkg::otp_s otp_i, // otp bytes
    input wire logic host_release_i, // host release
    input wire logic second_aux_pin_i, // pad level
    input wire logic second_aux_pin_o, // pad data
    input wire logic second_aux_pin_oe_o, // pad enable
    input wire logic [6:0] i2c_address_o, // address
    input wire logic [1:0] profile_o, // profile
    input wire logic hall_comp_en_i, // comp enable
    input wire logic [15:0] hall_threshold_counts_i, // nominal
    input wire logic [15:0] hall_out_i, // hall out
    input wire logic [15:0] hall_ref_i, // hall ref
    input wire logic [15:0] hall_threshold_counts_o // effective
);
    localparam logic [1:0] PS = aux_pin_pkg::PROFILE_STRAP;
    localparam logic [1:0] PF = aux_pin_pkg::PROFILE_FORCED;
    logic act;
    assign act = second_aux_pin_oe_o && (second_aux_pin_o != otp_i.system_byte[0]);
    function automatic logic [15:0] scaled(input logic e, input logic [15:0] t, o, r);
        return (e && r != 16'h0) ? 16'((32'(t) * 32'(o)) / 32'(r)) : t;
    endfunction
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    profile_copy_a: assert property (profile_o == otp_i.profile_byte[1:0])
        else $error("profile output differs from otp field");
    strap_input_a: assert property (profile_o == PS |-> !second_aux_pin_oe_o)
        else $error("pin driven in strap profile");
    od_low_a: assert property (otp_i.system_byte[0] |-> !second_aux_pin_o)
        else $error("open drain pin data high");
    pp_drive_a: assert property (!$past(rst_i) && !otp_i.system_byte[0] && profile_o != PS
        |-> second_aux_pin_oe_o)
        else $error("push pull pin not driven");
    addr_load_a: assert property ($past(rst_i) |=> i2c_address_o == (($past(otp_i.system_byte[1])
        ? 7'h45 : 7'h44) | {5'h0, $past(profile_o) == PS && !$past(second_aux_pin_i), 1'b0}))
        else $error("address wrong after reset");
    addr_hold_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> $stable(i2c_address_o))
        else $error("address changed at runtime");
    forced_level_a: assert property (profile_o == PF && !$past(rst_i) && !$past(host_release_i)
        |-> act)
        else $error("forced pin not active");
    release_drop_a: assert property ((profile_o == PF && host_release_i) [*3] |-> !act)
        else $error("pin active after host release");
    // touch hold never spans five seconds in these runs
    no_pulse_a: assert property (profile_o != PF |-> !act)
        else $error("pin active outside forced profile");
    hall_scale_a: assert property (!$past(rst_i) |-> hall_threshold_counts_o == scaled(
        $past(hall_comp_en_i), $past(hall_threshold_counts_i), $past(hall_out_i),
        $past(hall_ref_i)))
        else $error("hall threshold wrong");
    cover property (act);
    cover property ($past(rst_i) ##1 i2c_address_o[1]);
    cover property (hall_comp_en_i && hall_ref_i != 16'h0);
endmodule

// ---- verification/reset_profile_aux_pin_logic_tb.sv ----
`timescale 1ns/1ps
module reset_profile_aux_pin_logic_tb;
    logic clock_i = 1'b0, rst_i = 1'b1, touch = 1'b0, rel = 1'b0, strap_low = 1'b0, en = 1'b0;
    aux_pin_pkg::otp_s otp = '0;
    logic [15:0] thr = '0, hout = '0, href = '0, tho, e;
    logic pin_o, oe, lvl, fa;
    logic [6:0] addr;
    integer seed = 88, mismatches = 0, checks_done = 0, i, j;
    reset_profile_aux_pin_logic dut_u (.clock_i(clock_i), .rst_i(rst_i), .otp_i(otp),
        .self_cap_touch_i(touch), .host_release_i(rel), .second_aux_pin_i(lvl),
        .second_aux_pin_o(pin_o), .second_aux_pin_oe_o(oe), .i2c_address_o(addr),
        .profile_o(), .hall_comp_en_i(en), .hall_threshold_counts_i(thr), .hall_out_i(hout),
        .hall_ref_i(href), .hall_threshold_counts_o(tho));
    aux_pad_model pad_u (.out_i(pin_o), .oe_i(oe), .strap_low_i(strap_low), .level_o(lvl));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check_num(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask
    // {data, enable}; strap leaves the pad released
    function automatic logic [1:0] exp_pin(input logic [1:0] p, input logic pol, input logic a);
        if (p == aux_pin_pkg::PROFILE_STRAP) return 2'h0;
        return pol ? {1'b0, a} : {a, 1'b1};
    endfunction
    function automatic logic [15:0] exp_hall(input logic n, input logic [15:0] t, o, r);
        return (n && r != 16'h0) ? 16'((32'(t) * 32'(o)) / 32'(r)) : t;
    endfunction
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        repeat (6) @(posedge clock_i);
        for (i = 0; i < 32; i++) begin
            rst_i <= 1'b1;
            rel <= 1'b0;
            otp <= {6'h0, i[3], i[2], 6'h0, i[1:0]};
            strap_low <= i[4];
            repeat (2) @(posedge clock_i);
            rst_i <= 1'b0;
            repeat (2) @(posedge clock_i);
            fa = (i[1:0] == 2'h3);
            for (j = 0; j < 40; j++) begin
                @(posedge clock_i);
                e = exp_hall(en, thr, hout, href);
                // strap flipped after reset must not move the address
                if (j == 0) strap_low <= ~strap_low;
                if (j == 30) rel <= 1'b1;
                touch <= $random(seed);
                en <= $random(seed);
                thr <= {1'b0, 15'($random(seed))};
                hout <= {1'b0, 15'($random(seed))};
                href <= (j % 8 == 0) ? 16'h0 : {2'h1, 14'($random(seed))};
                #1;
                if (j > 0) check_num("hall", e, tho);
                if (j < 31 || j > 32)
                    check_num("pin", {14'h0, exp_pin(i[1:0], i[2], fa && j < 31)}, {14'h0, pin_o, oe});
            end
            check_num("addr", {9'h0, (i[3] ? 7'h45 : 7'h44) | ((i[1:0] == 2'h2 && i[4]) ? 7'h02 : 7'h00)}, {9'h0, addr});
        end
        stop_test();
    end
endmodule
bind reset_profile_aux_pin_logic aux_pin_props chk_u (.*);
